/* tpz_pkg.sv */
// package: constants and types for the z3/z4 overhead insertion block
package tpz_pkg;
   localparam int unsigned TPZ_SYS_HZ = 10_000_000;
   // half period of the overhead port clock, in sys_clk cycles
   localparam int unsigned TPZ_CLK_HALF = 4;
   // path overhead bytes in the serial slot, frame mark starts byte 0
   localparam int unsigned TPZ_POH_BYTES = 9;
   localparam int unsigned TPZ_BITS = 8;
   // serial slot positions: z3 is the seventh byte, z4 the eighth
   localparam logic [6:0] TPZ_Z3_START = 7'h30;
   localparam logic [6:0] TPZ_Z4_START = 7'h38;
   localparam logic [6:0] TPZ_SLOT_LAST = 7'h47;
   // host wait after frame mark, in port clock periods
   localparam logic [6:0] TPZ_Z3_WAIT = 7'h30;
   localparam logic [6:0] TPZ_Z4_WAIT = 7'h38;
   // control register field positions
   localparam int unsigned TPZ_SEL_Z3_BIT = 1;
   localparam int unsigned TPZ_SEL_Z4_BIT = 2;
   localparam logic [7:0] TPZ_SEL_RW_MASK = 8'h0F;
   localparam logic [7:0] TPZ_SEL_RESET = 8'h00;
   localparam logic [7:0] TPZ_Z4_RESET = 8'h00;
   localparam logic [7:0] TPZ_Z3_RESET = 8'h00;
   // wishbone word offsets of the device registers
   localparam logic [3:0] TPZ_ADR_SEL = 4'h0;
   localparam logic [3:0] TPZ_ADR_Z3 = 4'h4;
   localparam logic [3:0] TPZ_ADR_Z4 = 4'h8;
   localparam logic [3:0] TPZ_ADR_OUT = 4'hC;
   // host command registers
   localparam logic [3:0] TPZ_HADR_CTL = 4'h0;
   localparam logic [3:0] TPZ_HADR_Z3 = 4'h4;
   localparam logic [3:0] TPZ_HADR_Z4 = 4'h8;
   localparam logic [3:0] TPZ_HADR_STAT = 4'hC;
   typedef enum logic [2:0] {
      TPZ_H_IDLE = 3'b001,
      TPZ_H_WAIT = 3'b010,
      TPZ_H_SHIFT = 3'b100
   } tpz_hstate_e;
endpackage : tpz_pkg

/* tpz_link_if.sv */
// interface: serial overhead link between device and external circuit
interface tpz_link_if;
   logic overhead_port_clock;
   logic overhead_slot_enable;
   logic overhead_frame_mark;
   logic overhead_serial_in;
   logic overhead_insert_request;
   modport device (
      output overhead_port_clock,
      output overhead_slot_enable,
      output overhead_frame_mark,
      input overhead_serial_in,
      input overhead_insert_request
   );
   modport host (
      input overhead_port_clock,
      input overhead_slot_enable,
      input overhead_frame_mark,
      output overhead_serial_in,
      output overhead_insert_request
   );
endinterface : tpz_link_if

/* tpz_device.sv */
// device end: z3/z4 source select, value registers and serial capture

// one frame is 72 port clock slots; the mark flags slot 0, z3 fills
// slots 48..55 and z4 slots 56..63, both msb first
module tpz_device
   import tpz_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   output logic [7:0] z3_outbound,
   output logic [7:0] z4_outbound,
   output logic spe_strobe,
   tpz_link_if.device link
);
   import tpz_pkg::*;

   typedef struct packed {
      // software registers
      logic [7:0] sel;
      logic [7:0] z3_val;
      logic [7:0] z4_val;
      // bus answer
      logic [31:0] dat;
      logic ack;
      // port clock divider and slot counter
      logic [2:0] div;
      logic pclk;
      logic [6:0] slot;
      logic en;
      logic mark;
      // serial capture, behind two synchroniser flops
      logic sin_m;
      logic sin_s;
      logic [7:0] shreg;
      logic [7:0] z3_port;
      logic [7:0] z4_port;
      // bytes handed to the outbound spe
      logic [7:0] z3_out;
      logic [7:0] z4_out;
      logic strobe;
   } tpz_dev_s;

   tpz_dev_s q, d;
   logic wr;
   logic fall;
   logic in_z3;
   logic in_z4;
   logic z3_done;
   logic z4_done;
   logic frame_done;
   logic [7:0] port_byte;

   assign link.overhead_port_clock = q.pclk;
   assign link.overhead_slot_enable = q.en;
   assign link.overhead_frame_mark = q.mark;
   assign wb_dat_o = q.dat;
   assign wb_ack_o = q.ack;
   assign z3_outbound = q.z3_out;
   assign z4_outbound = q.z4_out;
   assign spe_strobe = q.strobe;

   always_comb
   begin
      d = q;
      d.strobe = 1'b0;
      // serial input comes from another party: two flops first
      d.sin_m = link.overhead_serial_in;
      d.sin_s = q.sin_m;

      // register bus: ack one cycle after the request, low lane only
      // insert request is ignored: the control bits pick the source
      wr = wb_cyc_i && wb_stb_i && wb_we_i && !q.ack && wb_sel_i[0];
      d.ack = wb_cyc_i && wb_stb_i && !q.ack;
      if (wr)
      begin
         case (wb_adr_i)
            TPZ_ADR_SEL:
            begin
               d.sel = wb_dat_i[7:0] & TPZ_SEL_RW_MASK;
            end
            TPZ_ADR_Z3:
            begin
               d.z3_val = wb_dat_i[7:0];
            end
            TPZ_ADR_Z4:
            begin
               d.z4_val = wb_dat_i[7:0];
            end
            default:
            begin
               // unmapped and read-only offsets ignore writes
               d.sel = q.sel;
            end
         endcase
      end
      case (wb_adr_i)
         TPZ_ADR_SEL:
         begin
            d.dat = {24'h000000, q.sel};
         end
         TPZ_ADR_Z3:
         begin
            d.dat = {24'h000000, q.z3_val};
         end
         TPZ_ADR_Z4:
         begin
            d.dat = {24'h000000, q.z4_val};
         end
         TPZ_ADR_OUT:
         begin
            d.dat = {16'h0000, q.z4_out, q.z3_out};
         end
         default:
         begin
            d.dat = 32'h00000000;
         end
      endcase

      // port clock divider: one enable pulse per period, on the falling edge
      fall = 1'b0;
      if (q.div == 3'(TPZ_CLK_HALF - 1))
      begin
         d.div = 3'h0;
         d.pclk = !q.pclk;
         fall = q.pclk;
      end
      else
      begin
         d.div = q.div + 3'h1;
      end

      // frame mark and enable change on falling port clock edges
      if (fall)
      begin
         d.slot = (q.slot == TPZ_SLOT_LAST) ? 7'h00 : q.slot + 7'h01;
         d.mark = (d.slot == 7'h00);
         d.en = 1'b1;
      end

      // slot k carries the bit that the host drove at the start of slot k
      in_z3 = (q.slot >= TPZ_Z3_START) && (q.slot < TPZ_Z4_START);
      in_z4 = (q.slot >= TPZ_Z4_START)
         && (q.slot < 7'(TPZ_Z4_START + TPZ_BITS));
      z3_done = in_z3 && (q.slot == TPZ_Z4_START - 7'h01);
      z4_done = in_z4 && (q.slot == 7'(TPZ_Z4_START + TPZ_BITS - 1));
      frame_done = (q.slot == TPZ_SLOT_LAST);
      port_byte = {q.shreg[6:0], q.sin_s};

      // the bit is taken in the last cycle of the high phase, not just
      // after the rising edge: the trip through both ends' synchronisers
      // is longer than half a port clock period
      if (fall)
      begin
         d.shreg = port_byte;
         if (z3_done)
         begin
            d.z3_port = port_byte;
         end
         if (z4_done)
         begin
            d.z4_port = port_byte;
         end
         // bytes after z4 are shifted through and never used
         if (frame_done)
         begin
            // independent muxes, any combination of sources
            d.z3_out = q.sel[TPZ_SEL_Z3_BIT] ? q.z3_port : q.z3_val;
            d.z4_out = q.sel[TPZ_SEL_Z4_BIT] ? q.z4_port : q.z4_val;
            d.strobe = 1'b1;
         end
      end

      if (!nrst)
      begin
         d = '0;
         d.sel = TPZ_SEL_RESET;
         d.z3_val = TPZ_Z3_RESET;
         d.z4_val = TPZ_Z4_RESET;
         d.slot = TPZ_SLOT_LAST;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      q <= d;
   end
endmodule : tpz_device

/* tpz_host.sv */
// host end: external circuit that shifts z3 and z4 into the device
module tpz_host
   import tpz_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [3:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   tpz_link_if.host link
);
   import tpz_pkg::*;

   typedef struct packed {
      logic [1:0] ctl;
      logic [7:0] z3;
      logic [7:0] z4;
      logic [31:0] dat;
      logic ack;
      logic [2:0] clk_s;
      logic [1:0] en_s;
      logic [1:0] mk_s;
      tpz_hstate_e st;
      logic [6:0] cnt;
      logic [7:0] sh;
      logic [3:0] bits;
      logic z4_next;
      logic sout;
      logic [7:0] frames;
   } tpz_host_s;

   tpz_host_s q, d;
   logic rise, fall, wr;

   assign link.overhead_serial_in = q.sout;
   assign link.overhead_insert_request = q.ctl[0];
   assign wb_dat_o = q.dat;
   assign wb_ack_o = q.ack;

   always_comb
   begin
      d = q;
      d.clk_s = {q.clk_s[1:0], link.overhead_port_clock};
      d.en_s = {q.en_s[0], link.overhead_slot_enable};
      d.mk_s = {q.mk_s[0], link.overhead_frame_mark};
      rise = q.clk_s[1] && !q.clk_s[2];
      fall = !q.clk_s[1] && q.clk_s[2];
      wr = wb_cyc_i && wb_stb_i && wb_we_i && !q.ack && wb_sel_i[0];
      d.ack = wb_cyc_i && wb_stb_i && !q.ack;
      if (wr)
      begin
         case (wb_adr_i)
            TPZ_HADR_CTL: d.ctl = wb_dat_i[1:0];
            TPZ_HADR_Z3: d.z3 = wb_dat_i[7:0];
            TPZ_HADR_Z4: d.z4 = wb_dat_i[7:0];
            default: d.ctl = q.ctl;
         endcase
      end
      case (wb_adr_i)
         TPZ_HADR_CTL: d.dat = {30'h0, q.ctl};
         TPZ_HADR_Z3: d.dat = {24'h000000, q.z3};
         TPZ_HADR_Z4: d.dat = {24'h000000, q.z4};
         TPZ_HADR_STAT: d.dat = {21'h0, q.st, q.frames};
         default: d.dat = 32'h00000000;
      endcase
      case (q.st)
         TPZ_H_IDLE:
         begin
            if (rise && q.en_s[1] && q.mk_s[1] && q.ctl[1])
            begin
               d.st = TPZ_H_WAIT;
               d.cnt = 7'h00;
               d.z4_next = 1'b0;
               d.frames = q.frames + 8'h01;
            end
         end
         TPZ_H_WAIT:
         begin
            if (rise)
            begin
               d.cnt = q.cnt + 7'h01;
            end
            // then msb on the falling edge after the wait
            if (fall && q.cnt >= (q.z4_next ? TPZ_Z4_WAIT : TPZ_Z3_WAIT)
               - 7'h01)
            begin
               d.sh = q.z4_next ? q.z4 : q.z3;
               d.sout = d.sh[7];
               d.bits = 4'h1;
               d.st = TPZ_H_SHIFT;
            end
         end
         TPZ_H_SHIFT:
         begin
            if (fall)
            begin
               if (q.bits == 4'(TPZ_BITS))
               begin
                  // z4 follows z3 directly, then rearm
                  d.z4_next = !q.z4_next;
                  d.st = q.z4_next ? TPZ_H_IDLE : TPZ_H_SHIFT;
                  d.sh = q.z4;
                  d.sout = q.z4[7];
                  d.bits = 4'h1;
               end
               else
               begin
                  d.sh = {q.sh[6:0], 1'b0};
                  d.sout = q.sh[6];
                  d.bits = q.bits + 4'h1;
               end
            end
         end
         default: d.st = TPZ_H_IDLE;
      endcase
      if (!nrst)
      begin
         d = '0;
         d.st = TPZ_H_IDLE;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      q <= d;
   end
endmodule : tpz_host

/* tpz_link_assertions.sv */
// checker: timing of the serial overhead link between the two ends
module tpz_link_assertions (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic overhead_port_clock,
   input wire logic overhead_slot_enable,
   input wire logic overhead_frame_mark,
   input wire logic overhead_serial_in
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   wire ck = overhead_port_clock;
   wire en = overhead_slot_enable;
   wire mk = overhead_frame_mark;
   wire si = overhead_serial_in;
   logic [9:0] gap_q;
   logic seen_q;
   // frame length counted here: 576 cycles is too long for a delay
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         gap_q <= 10'h000;
         seen_q <= 1'b0;
      end
      else
      begin
         gap_q <= $rose(mk) ? 10'h001 : gap_q + 10'h001;
         seen_q <= seen_q | $rose(mk);
      end
   end
   sequence s_hi;
      ck [*4] ##1 !ck;
   endsequence
   sequence s_lo;
      !ck [*4] ##1 ck;
   endsequence
   chk_clk_high: assert property ($rose(ck) |-> s_hi)
      else $error("port clock high time wrong");
   chk_clk_low: assert property ($fell(ck) |-> s_lo)
      else $error("port clock low time wrong");
   chk_mark_len: assert property ($rose(mk) |-> mk [*8] ##1 !mk)
      else $error("frame mark width wrong");
   chk_mark_enable: assert property (mk && $rose(ck) |-> en)
      else $error("frame mark without slot enable");
   chk_mark_fall: assert property ($changed(mk) |-> !ck)
      else $error("frame mark moved while clock high");
   chk_enable_fall: assert property ($changed(en) |-> !ck)
      else $error("slot enable moved while clock high");
   chk_data_fall: assert property ($changed(si) |-> !ck)
      else $error("serial data moved while clock high");
   chk_frame_len: assert property (seen_q && $rose(mk) |-> gap_q == 10'h240)
      else $error("frame period wrong");
endmodule : tpz_link_assertions

/* tx_path_overhead_z3_z4_insert_tb_top.sv */
// testbench: both ends joined, every z3/z4 source combination
module tx_path_overhead_z3_z4_insert_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import tpz_pkg::*;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wd = 32'h0;
   logic we = 1'b0;
   logic cd = 1'b0;
   logic ch = 1'b0;
   logic [31:0] rd_d, rd_h;
   logic ak_d, ak_h, stb;
   logic [7:0] z3o, z4o;
   int error_cnt = 0;
   int n_compared = 0;
   tpz_link_if link_inst ();
   tpz_device tpz_device_inst (.sys_clk(sys_clk), .nrst(nrst),
      .wb_adr_i(adr), .wb_dat_i(wd), .wb_dat_o(rd_d), .wb_we_i(we),
      .wb_sel_i(4'hF), .wb_cyc_i(cd), .wb_stb_i(cd), .wb_ack_o(ak_d),
      .z3_outbound(z3o), .z4_outbound(z4o), .spe_strobe(stb),
      .link(link_inst));
   tpz_host tpz_host_inst (.sys_clk(sys_clk), .nrst(nrst),
      .wb_adr_i(adr), .wb_dat_i(wd), .wb_dat_o(rd_h), .wb_we_i(we),
      .wb_sel_i(4'hF), .wb_cyc_i(ch), .wb_stb_i(ch), .wb_ack_o(ak_h),
      .link(link_inst));
   tpz_link_assertions tpz_link_assertions_inst (.sys_clk(sys_clk),
      .nrst(nrst), .overhead_port_clock(link_inst.overhead_port_clock),
      .overhead_slot_enable(link_inst.overhead_slot_enable),
      .overhead_frame_mark(link_inst.overhead_frame_mark),
      .overhead_serial_in(link_inst.overhead_serial_in));
   initial
   begin
      forever #50 sys_clk = ~sys_clk;
   end
   task print_verdict;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict
   task chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e)
      begin
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
         error_cnt++;
      end
   endtask : chk
   // h selects the host end; both ends share address and data lines
   task wb(input bit h, input bit w, input logic [3:0] a,
      input logic [7:0] d, output logic [31:0] r);
      int n;
      @(posedge sys_clk);
      adr <= a;
      wd <= {24'h0, d};
      we <= w;
      {ch, cd} <= h ? 2'b10 : 2'b01;
      for (n = 0; n < 40; n++)
      begin
         @(posedge sys_clk);
         if ((h ? ak_h : ak_d) === 1'b1)
            break;
      end
      r = h ? rd_h : rd_d;
      {ch, cd} <= 2'b00;
      if (n == 40)
      begin
         error_cnt++;
         print_verdict();
      end
   endtask : wb
   task wait_stb(output int g);
      for (g = 1; g < 1000; g++)
      begin
         @(posedge sys_clk);
         if (stb === 1'b1)
            break;
      end
      if (g == 1000)
      begin
         error_cnt++;
         print_verdict();
      end
   endtask : wait_stb
   initial
   begin
      logic [31:0] r;
      logic [7:0] v3, v4, h3, h4, e3, e4;
      logic [3:0] al [5];
      logic [1:0] m;
      int g;
      logic ins;
      al = '{TPZ_ADR_SEL, TPZ_ADR_Z3, TPZ_ADR_Z4, TPZ_ADR_OUT, 4'h2};
      void'($urandom(32'h93E4));
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         wb(1'b0, 1'b0, al[i], 8'h00, r);
         chk(r, 32'h0);
      end
      // unmapped write, then select write: select keeps its low four bits, unmapped offset reads zero
      wb(1'b0, 1'b1, 4'h2, 8'hFF, r);
      wb(1'b0, 1'b1, TPZ_ADR_SEL, 8'hF9, r);
      wb(1'b0, 1'b0, TPZ_ADR_SEL, 8'h00, r);
      chk(r, 32'h9);
      wb(1'b0, 1'b0, 4'h2, 8'h00, r);
      chk(r, 32'h0);
      $display("test reset_map done");
      ins = 1'($urandom);
      wb(1'b1, 1'b1, TPZ_HADR_CTL, {7'h1, ins}, r);
      wb(1'b1, 1'b0, TPZ_HADR_CTL, 8'h00, r);
      chk(r, {30'h0, 1'b1, ins});
      chk({31'h0, link_inst.overhead_insert_request}, {31'h0, ins});
      for (int i = 0; i < 8; i++)
      begin
         m = i[1:0];
         v3 = 8'($urandom);
         v4 = 8'($urandom);
         h3 = (i == 0) ? 8'h80 : 8'($urandom);
         h4 = (i == 0) ? 8'h01 : 8'($urandom);
         e3 = m[0] ? h3 : v3;
         e4 = m[1] ? h4 : v4;
         wb(1'b0, 1'b1, TPZ_ADR_SEL, {5'h0, m, 1'b0}, r);
         wb(1'b0, 1'b1, TPZ_ADR_Z3, v3, r);
         wb(1'b0, 1'b1, TPZ_ADR_Z4, v4, r);
         wb(1'b1, 1'b1, TPZ_HADR_Z3, h3, r);
         wb(1'b1, 1'b1, TPZ_HADR_Z4, h4, r);
         wb(1'b1, 1'b0, TPZ_HADR_Z3, 8'h00, r);
         chk(r, {24'h0, h3});
         // first frames may straddle the reconfiguration
         repeat (3) wait_stb(g);
         chk(32'(g), 32'd576);
         chk({24'h0, z3o}, {24'h0, e3});
         chk({24'h0, z4o}, {24'h0, e4});
         wb(1'b0, 1'b0, TPZ_ADR_OUT, 8'h00, r);
         chk(r, {16'h0, e4, e3});
         $display("test combo %0d done", i);
      end
      print_verdict();
   end
endmodule : tx_path_overhead_z3_z4_insert_tb_top
